// ==== design/spf_consts.svh ====
// constants for shared pin function control
`ifndef SPF_CONSTS_SVH
`define SPF_CONSTS_SVH
// ==========================================================
// register offsets (byte addresses)
`define SPF_ADDR_CFGA 8'h00
`define SPF_ADDR_CFGB 8'h04
`define SPF_ADDR_CNT 8'h08
`define SPF_ADDR_PORT 8'h0C
`define SPF_ADDR_INREG 8'h10
`define SPF_ADDR_FLAG 8'h14
`define SPF_ADDR_CTRL 8'h18
`define SPF_ADDR_IRQEN 8'h1C
// ==========================================================
// field positions
`define SPF_CFGA_HIGH_FREQ_COUNTER_PIN_BIT 0
`define SPF_CFGA_LOW_FREQ_COUNTER_PIN_BIT 1
`define SPF_CFGA_AN_LSB 8
`define SPF_CFGA_KDIR_LSB 16
`define SPF_CFGA_CHAN_LSB 20
`define SPF_CFGB_PUMP_BIT 0
`define SPF_CNT_PERIOD_BIT 0
`define SPF_CNT_START_BIT 1
`define SPF_INREG_HIGH_FREQ_COUNTER_PIN_BIT 0
`define SPF_INREG_LOW_FREQ_COUNTER_PIN_BIT 1
`define SPF_INREG_PUMP_BIT 2
`define SPF_FLAG_SENSE_BIT 0
`define SPF_FLAG_SNSPIN_BIT 1
`define SPF_FLAG_PWROFF_BIT 2
`define SPF_FLAG_HOLDIRQ_BIT 3
`define SPF_FLAG_BACKUP_BIT 4
`define SPF_CTRL_CLOCK_STOP_INSTR_BIT 0
`define SPF_CTRL_PLLSTOP_BIT 1
// ==========================================================
// reset values and timing
`define SPF_CFGA_RST 32'h0000_0000
`define SPF_CLK_HZ 20000000
`define SPF_MACHINE_NS 1330
`define SPF_MACHINE_CYC ((`SPF_MACHINE_NS * (`SPF_CLK_HZ / 1000000) + 999) / 1000)
`endif

// ==== design/spf_pin_ctrl.sv ====
// shared pin function control with wishbone register access
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "spf_consts.svh"
// ==========================================================
// Overview of operation
// - pump pin low when divided LO above reference, high below, floats on match
// - config b picks pump output or plain input; input level read back
// - pump pin high impedance in backup and after power-on reset
// - pump pin also high impedance while the pll is stopped
// - config a picks counter frequency use or plain input for high counter pin
// - high counter pin level returned in bit 0 of input register
// - backup disables both counter pin inputs and pulls them down
// - power-on reset selects counter use, frequency mode on high pin
// - low counter pin measures frequency or period; period drops bias resistor
// - low counter pin level returned in bit 1 of input register
// - supply sense pin feeds sense flop; both testable via flag register
// - supply sense input stays enabled in backup and after reset
// - power-off on monitor pin sets power-off flag and hold irq flag
// - clock stop with monitor low enters backup; monitor high leaves it
// - reset pin low one machine cycle resets and sets sense flop
// - analog inputs chosen per bit with channel; counter control starts conversion
// - analog-assigned bits read low on digital input
// - open-drain outputs off in backup and after reset
// - interrupt io direction per bit; enable flag needs input mode
// - interrupt io inputs disabled, outputs floating in backup; inputs after reset
module spf_pin_ctrl #(
  parameter int AN_W = 8,
  parameter int IO_W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wishbone slave
  input wire spf_pkg::spf_wbreq_t wbReq,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // pll compare and status
  input wire logic pllUp,
  input wire logic pllDown,
  // pins
  input wire logic resetPinN,
  input wire logic holdPin,
  input wire logic senseIn,
  input wire logic hctrIn,
  input wire logic lctrIn,
  input wire logic pumpIn,
  input wire logic [AN_W-1:0] anIn,
  input wire logic [IO_W-1:0] ioIn,
  output spf_pkg::spf_pin_t pumpPin,
  output logic hctrPullDown,
  output logic lctrPullDown,
  output logic lctrBiasOff,
  output logic [IO_W-1:0] odOe,
  output logic [IO_W-1:0] ioOut,
  output logic [IO_W-1:0] ioOe,
  // to counter, converter and interrupt logic
  output logic cntHctrSel,
  output logic cntLctrSel,
  output logic cntPeriod,
  output logic cntStart,
  output logic [AN_W-1:0] anSel,
  output logic [2:0] anChan,
  output logic [IO_W-1:0] irqReq,
  output logic cpuReset,
  output logic backup
);
  initial begin
    if (AN_W < 1 || AN_W > 8 || IO_W < 1 || IO_W > 4) begin
      $error("spf_pin_ctrl: unsupported width");
    end
  end

  // ==========================================================
  // pin synchronisers
  localparam int SW = 5 + AN_W + IO_W;
  logic [SW-1:0] syncA;
  logic [SW-1:0] syncB;
  always_ff @(posedge clk) begin
    syncA <= {resetPinN, holdPin, senseIn, hctrIn, lctrIn, anIn, ioIn};
    syncB <= syncA;
  end
  logic sResetN;
  logic sHold;
  logic sSense;
  logic sHctr;
  logic sLctr;
  logic [AN_W-1:0] sAn;
  logic [IO_W-1:0] sIo;
  assign {sResetN, sHold, sSense, sHctr, sLctr, sAn, sIo} = syncB;
  logic sPump;
  logic pumpSyncA;
  always_ff @(posedge clk) begin
    pumpSyncA <= pumpIn;
    sPump <= pumpSyncA;
  end

  // ==========================================================
  // bus decode
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    return adr == off;
  endfunction
  logic access;
  logic wrEn;
  assign access = wbReq.cyc && wbReq.stb && !wbAck;
  assign wrEn = access && wbReq.we && (wbReq.sel == 4'hF);

  // ==========================================================
  // reset pin: low for one machine cycle resets the core
  localparam int MC = `SPF_MACHINE_CYC;
  logic [7:0] lowCnt;
  always_ff @(posedge clk) begin
    if (rst || sResetN) begin
      lowCnt <= 8'h00;
      cpuReset <= rst;
    end else if (lowCnt < 8'(MC)) begin
      lowCnt <= lowCnt + 8'h01;
      cpuReset <= 1'b0;
    end else begin
      cpuReset <= 1'b1;
    end
  end
  logic sysRst;
  assign sysRst = rst || cpuReset;

  // ==========================================================
  // configuration latches
  logic [31:0] cfgA;
  logic pumpMode;
  logic [IO_W-1:0] odData;
  logic [IO_W-1:0] ioData;
  logic [IO_W-1:0] irqEn;
  logic pllStop;
  always_ff @(posedge clk) begin
    if (sysRst) begin
      cfgA <= `SPF_CFGA_RST;
      pumpMode <= 1'b0;
    end else if (wrEn && hit(wbReq.adr, `SPF_ADDR_CFGA)) begin
      cfgA <= wbReq.dat;
    end else if (wrEn && hit(wbReq.adr, `SPF_ADDR_CFGB)) begin
      pumpMode <= wbReq.dat[`SPF_CFGB_PUMP_BIT];
    end
  end
  always_ff @(posedge clk) begin
    if (sysRst) begin
      odData <= '1;
      ioData <= '0;
      irqEn <= '0;
      pllStop <= 1'b1;
      cntPeriod <= 1'b0;
    end else if (wrEn) begin
      if (hit(wbReq.adr, `SPF_ADDR_PORT)) begin
        odData <= wbReq.dat[IO_W-1:0];
        ioData <= wbReq.dat[8+:IO_W];
      end
      if (hit(wbReq.adr, `SPF_ADDR_IRQEN)) begin
        irqEn <= wbReq.dat[IO_W-1:0];
      end
      if (hit(wbReq.adr, `SPF_ADDR_CTRL)) begin
        pllStop <= wbReq.dat[`SPF_CTRL_PLLSTOP_BIT];
      end
      if (hit(wbReq.adr, `SPF_ADDR_CNT)) begin
        cntPeriod <= wbReq.dat[`SPF_CNT_PERIOD_BIT];
      end
    end
  end
  logic [IO_W-1:0] ioDir;
  assign ioDir = cfgA[`SPF_CFGA_KDIR_LSB+:IO_W];

  // ==========================================================
  // backup mode
  spf_pkg::spf_mode_t mode;
  logic ckstpWr;
  assign ckstpWr = wrEn && hit(wbReq.adr, `SPF_ADDR_CTRL) && wbReq.dat[`SPF_CTRL_CLOCK_STOP_INSTR_BIT];
  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= spf_pkg::SPF_RUN;
    end else begin
      unique case (mode)
        spf_pkg::SPF_RUN: begin
          if (ckstpWr && !sHold) begin
            mode <= spf_pkg::SPF_BACKUP;
          end
        end
        spf_pkg::SPF_BACKUP: begin
          if (sHold) begin
            mode <= spf_pkg::SPF_RUN;
          end
        end
        default: mode <= spf_pkg::SPF_RUN;
      endcase
    end
  end
  logic inBackup;
  assign inBackup = (mode == spf_pkg::SPF_BACKUP);

  // ==========================================================
  // flags; a new event wins over a software clear
  logic holdPrev;
  logic senseFf;
  logic pwrOff;
  logic holdIrq;
  logic holdFall;
  logic flagClr;
  assign holdFall = holdPrev && !sHold;
  assign flagClr = wrEn && hit(wbReq.adr, `SPF_ADDR_FLAG);
  always_ff @(posedge clk) begin
    if (rst) begin
      holdPrev <= 1'b1;
    end else begin
      holdPrev <= sHold;
    end
  end
  always_ff @(posedge clk) begin
    if (sysRst) begin
      senseFf <= 1'b1;
    end else if (sSense) begin
      senseFf <= 1'b1;
    end else if (flagClr && wbReq.dat[`SPF_FLAG_SENSE_BIT]) begin
      senseFf <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      pwrOff <= 1'b0;
      holdIrq <= 1'b0;
    end else if (holdFall) begin
      pwrOff <= 1'b1;
      holdIrq <= 1'b1;
    end else if (flagClr) begin
      if (wbReq.dat[`SPF_FLAG_PWROFF_BIT]) pwrOff <= 1'b0;
      if (wbReq.dat[`SPF_FLAG_HOLDIRQ_BIT]) holdIrq <= 1'b0;
    end
  end

  // ==========================================================
  // pin drive and role outputs
  logic anyReset;
  assign anyReset = sysRst || inBackup;
  always_ff @(posedge clk) begin
    if (anyReset || pllStop || !pumpMode) begin
      pumpPin <= '0;
    end else begin
      // inverted sense against the main pump outputs
      pumpPin.oe <= pllUp ^ pllDown;
      pumpPin.out <= pllDown;
    end
  end
  always_ff @(posedge clk) begin
    hctrPullDown <= inBackup;
    lctrPullDown <= inBackup;
    lctrBiasOff <= cntPeriod && !cfgA[`SPF_CFGA_LOW_FREQ_COUNTER_PIN_BIT];
    cntHctrSel <= !cfgA[`SPF_CFGA_HIGH_FREQ_COUNTER_PIN_BIT] && !inBackup;
    cntLctrSel <= !cfgA[`SPF_CFGA_LOW_FREQ_COUNTER_PIN_BIT] && !inBackup;
    anSel <= inBackup ? '0 : cfgA[`SPF_CFGA_AN_LSB+:AN_W];
    anChan <= cfgA[`SPF_CFGA_CHAN_LSB+:3];
    cntStart <= wrEn && hit(wbReq.adr, `SPF_ADDR_CNT) && wbReq.dat[`SPF_CNT_START_BIT];
    odOe <= anyReset ? '0 : ~odData;
    ioOe <= anyReset ? '0 : ioDir;
    ioOut <= ioData;
    // interrupt only from pins in input mode
    irqReq <= (anyReset ? '0 : (irqEn & ~ioDir & sIo));
    backup <= inBackup;
  end

  // ==========================================================
  // read side
  logic [31:0] rdData;
  logic [AN_W-1:0] anDigital;
  logic [IO_W-1:0] ioDigital;
  assign anDigital = inBackup ? '0 : (sAn & ~cfgA[`SPF_CFGA_AN_LSB+:AN_W]);
  assign ioDigital = inBackup ? '0 : sIo;
  always_comb begin
    rdData = 32'h0000_0000;
    unique case (wbReq.adr)
      `SPF_ADDR_CFGA: rdData = cfgA;
      `SPF_ADDR_CFGB: rdData[`SPF_CFGB_PUMP_BIT] = pumpMode;
      `SPF_ADDR_CNT: rdData[`SPF_CNT_PERIOD_BIT] = cntPeriod;
      `SPF_ADDR_PORT: begin
        rdData[IO_W-1:0] = odData;
        rdData[8+:IO_W] = ioDigital;
        rdData[16+:AN_W] = anDigital;
      end
      `SPF_ADDR_INREG: begin
        rdData[`SPF_INREG_HIGH_FREQ_COUNTER_PIN_BIT] = cfgA[`SPF_CFGA_HIGH_FREQ_COUNTER_PIN_BIT] && !inBackup && sHctr;
        rdData[`SPF_INREG_LOW_FREQ_COUNTER_PIN_BIT] = cfgA[`SPF_CFGA_LOW_FREQ_COUNTER_PIN_BIT] && !inBackup && sLctr;
        rdData[`SPF_INREG_PUMP_BIT] = !pumpMode && sPump;
      end
      `SPF_ADDR_FLAG: begin
        rdData[`SPF_FLAG_SENSE_BIT] = senseFf;
        rdData[`SPF_FLAG_SNSPIN_BIT] = sSense;
        rdData[`SPF_FLAG_PWROFF_BIT] = pwrOff;
        rdData[`SPF_FLAG_HOLDIRQ_BIT] = holdIrq;
        rdData[`SPF_FLAG_BACKUP_BIT] = inBackup;
      end
      `SPF_ADDR_CTRL: rdData[`SPF_CTRL_PLLSTOP_BIT] = pllStop;
      `SPF_ADDR_IRQEN: rdData[IO_W-1:0] = irqEn;
      default: rdData = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wbAck <= 1'b0;
      wbDatO <= 32'h0000_0000;
    end else begin
      wbAck <= access;
      wbDatO <= access ? rdData : 32'h0000_0000;
    end
  end
endmodule

// ==== design/spf_pkg.sv ====
// types for shared pin function control
package spf_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } spf_wbreq_t;
  typedef struct packed {
    logic out;
    logic oe;
  } spf_pin_t;
  typedef enum logic [1:0] {
    SPF_RUN,
    SPF_BACKUP
  } spf_mode_t;
endpackage

// ==== dv/spf_board_model.sv ====
// board-side model: pin levels, supply monitor and reset circuit
`timescale 1ns/1ps
module spf_board_model (
  // clock and bench levels
  input wire logic clk,
  input wire logic [3:0] lvl,
  input wire logic hold,
  input wire logic rstReq,
  input wire logic [7:0] anLvl,
  input wire logic [3:0] ioLvl,
  // device outputs
  input wire spf_pkg::spf_pin_t pumpPin,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe,
  // device inputs
  output logic resetPinN,
  output logic holdPin,
  output logic senseIn,
  output logic hctrIn,
  output logic lctrIn,
  output logic pumpIn,
  output logic [7:0] anIn,
  output logic [3:0] ioIn
);
  // power-up low time shortened to keep the run short
  logic [5:0] upCnt = 6'h00;
  always_ff @(posedge clk) begin
    if (upCnt != 6'h28) begin
      upCnt <= upCnt + 6'h01;
    end
  end
  assign resetPinN = (upCnt == 6'h28) && !rstReq;
  assign holdPin = hold;
  assign {pumpIn, senseIn, lctrIn, hctrIn} = {pumpPin.oe ? pumpPin.out : lvl[3], lvl[2:0]};
  assign anIn = anLvl;
  // a pin the device drives shows its own level
  assign ioIn = (ioOe & ioOut) | (~ioOe & ioLvl);
endmodule

// ==== dv/spf_pin_ctrl_properties.sv ====
// assertion checker for the shared pin function control ports
`timescale 1ns/1ps
module spf_pin_ctrl_properties #(
  parameter int AN_W = 8,
  parameter int IO_W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire spf_pkg::spf_wbreq_t wbReq,
  input wire logic [31:0] wbDatO,
  input wire logic wbAck,
  // pll compare
  input wire logic pllUp,
  input wire logic pllDown,
  // pins and roles
  input wire spf_pkg::spf_pin_t pumpPin,
  input wire logic hctrPullDown,
  input wire logic lctrPullDown,
  input wire logic lctrBiasOff,
  input wire logic [IO_W-1:0] odOe,
  input wire logic [IO_W-1:0] ioOe,
  input wire logic cntHctrSel,
  input wire logic cntPeriod,
  input wire logic [AN_W-1:0] anSel,
  input wire logic backup
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========================================
  // bus and pins
  sequence s_req;
    wbReq.cyc && wbReq.stb && !wbAck;
  endsequence
  // outputs are registered, so backup must have stood one cycle first
  sequence s_held;
    backup [*2];
  endsequence
  chk_ack_next: assert property (s_req |=> wbAck)
    else $error("ack missing after request");
  chk_ack_pulse: assert property (wbAck |=> !wbAck && wbDatO == 32'h0000_0000)
    else $error("ack or read data stands too long");
  chk_pump_drive: assert property (pumpPin.oe |->
    $past(pllUp ^ pllDown) && pumpPin.out == $past(pllDown))
    else $error("pump pin level wrong");
  chk_pump_backup: assert property (s_held |-> !pumpPin.oe)
    else $error("pump pin driven in backup");
  chk_pins_backup: assert property (s_held |-> !(|odOe) && !(|ioOe))
    else $error("output drivers on in backup");
  chk_pull_backup: assert property (s_held |-> hctrPullDown && lctrPullDown && !cntHctrSel)
    else $error("counter pins not parked in backup");
  chk_reset_state: assert property ($fell(rst) |->
    !pumpPin.oe && !(|odOe) && !(|ioOe) && cntHctrSel && !(|anSel))
    else $error("wrong state after reset");
  // the bias output is registered, so it follows the period bit one cycle late
  chk_bias_period: assert property (lctrBiasOff |-> $past(cntPeriod))
    else $error("bias resistor off outside period mode");
endmodule
bind spf_pin_ctrl spf_pin_ctrl_properties #(.AN_W(AN_W), .IO_W(IO_W)) u_props (
  .clk(clk), .rst(rst), .wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck), .pllUp(pllUp), .pllDown(pllDown),
  .pumpPin(pumpPin), .hctrPullDown(hctrPullDown), .lctrPullDown(lctrPullDown), .lctrBiasOff(lctrBiasOff),
  .odOe(odOe), .ioOe(ioOe), .cntHctrSel(cntHctrSel), .cntPeriod(cntPeriod), .anSel(anSel), .backup(backup));

// ==== dv/spf_pin_ctrl_tb.sv ====
// self-checking bench for the shared pin function control block
`timescale 1ns/1ps
`include "spf_consts.svh"
module spf_pin_ctrl_tb;
  logic clk, rst, pllUp, pllDown, hold, rstReq, wbAck, resetPinN, holdPin, senseIn, hctrIn, lctrIn, pumpIn;
  logic hctrPullDown, lctrPullDown, lctrBiasOff, cntHctrSel, cntPeriod, cpuReset, backup;
  logic [2:0] anChan;
  logic [3:0] lvl, ioLvl, odOe, ioOut, ioOe, irqReq, ioIn;
  logic [7:0] anLvl, anSel, anIn;
  logic [31:0] wbDatO, rd;
  spf_pkg::spf_wbreq_t wbReq;
  spf_pkg::spf_pin_t pumpPin;
  int num_errors = 0;
  int comparisons = 0;
  spf_pin_ctrl DUT (.*, .cntLctrSel(), .cntStart());
  spf_board_model board (.*);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    bit got;
    got = 1'b0;
    wbReq <= '{1'b1, 1'b1, we, 4'hF, adr, dat};
    for (int n = 0; n < 20 && !got; n++) begin
      @(posedge clk);
      got = (wbAck === 1'b1);
    end
    rd = wbDatO;
    wbReq.cyc <= 1'b0;
    wbReq.stb <= 1'b0;
    @(posedge clk);
    if (!got) begin
      chk("bus ack", 32'h1, 32'h0);
      end_of_test();
    end
  endtask
  task automatic rdc(input string name, input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    chk(name, exp, rd & mask);
  endtask
  // input pins pass two sync flops and a register
  task automatic wt();
    repeat (6) @(posedge clk);
  endtask
  initial begin
    rst = 1'b1;
    {pllUp, pllDown, rstReq, hold} = 4'h1;
    {lvl, ioLvl, anLvl} = 16'h0000;
    wbReq = 47'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (90) @(posedge clk);
    rdc("cfgA", `SPF_ADDR_CFGA, 32'hFFFF_FFFF, 32'h0);
    rdc("flags", `SPF_ADDR_FLAG, 32'h1F, 32'h1);
    rdc("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0);
    chk("reset pins", 32'h1, 32'({pumpPin.oe, odOe, ioOe, cntHctrSel}));
    $display("test defaults done");
    bus(1'b1, `SPF_ADDR_CFGA, 32'h3);
    for (int i = 1; i < 3; i++) begin
      lvl <= 4'(i);
      wt();
      rdc("input reg", `SPF_ADDR_INREG, 32'h7, 32'(i));
    end
    chk("high_freq_counter_pin role", 32'h0, 32'(cntHctrSel));
    ioLvl <= 4'hC;
    anLvl <= 8'hFF;
    bus(1'b1, `SPF_ADDR_CFGA, 32'h0053_0F00);
    bus(1'b1, `SPF_ADDR_PORT, 32'h050A);
    bus(1'b1, `SPF_ADDR_IRQEN, 32'hC);
    wt();
    chk("analog role", 32'h50F, 32'({anChan, anSel}));
    rdc("analog read", `SPF_ADDR_PORT, 32'h00FF_0000, 32'h00F0_0000);
    chk("io pins", 32'h315, 32'({ioOe, ioOut & ioOe, odOe}));
    // enables on bits 2 and 3, both inputs and high; output bits never request
    chk("irq", 32'hC, 32'(irqReq));
    bus(1'b1, `SPF_ADDR_CNT, 32'h3);
    wt();
    chk("period", 32'h3, 32'({lctrBiasOff, cntPeriod}));
    $display("test roles done");
    bus(1'b1, `SPF_ADDR_CFGB, 32'h1);
    bus(1'b1, `SPF_ADDR_CTRL, 32'h0);
    for (int k = 0; k < 4; k++) begin
      {pllUp, pllDown} <= 2'(k);
      wt();
      chk("pump", 32'({k[1] ^ k[0], k[0] & ~k[1]}), 32'({pumpPin.oe, pumpPin.oe & pumpPin.out}));
    end
    {pllUp, pllDown} <= 2'h2;
    bus(1'b1, `SPF_ADDR_CTRL, 32'h2);
    wt();
    chk("pump stopped", 32'h0, 32'(pumpPin.oe));
    bus(1'b1, `SPF_ADDR_CTRL, 32'h0);
    lvl <= 4'h8;
    bus(1'b1, `SPF_ADDR_CFGB, 32'h0);
    wt();
    rdc("pump input", `SPF_ADDR_INREG, 32'h4, 32'h4);
    bus(1'b1, `SPF_ADDR_CFGB, 32'h1);
    $display("test pump done");
    hold <= 1'b0;
    lvl <= 4'h4;
    wt();
    rdc("hold flags", `SPF_ADDR_FLAG, 32'hE, 32'hE);
    bus(1'b1, `SPF_ADDR_CTRL, 32'h1);
    wt();
    chk("backup", 32'h1C00, 32'({backup, hctrPullDown, lctrPullDown, pumpPin.oe, odOe, ioOe, cntHctrSel}));
    chk("irq backup", 32'h0, 32'(irqReq));
    // sense pin still high: a disabled input would read low here
    rdc("sense raw", `SPF_ADDR_FLAG, 32'h2, 32'h2);
    lvl <= 4'h0;
    hold <= 1'b1;
    wt();
    chk("backup exit", 32'h0, 32'(backup));
    bus(1'b1, `SPF_ADDR_FLAG, 32'hD);
    rdc("flags clear", `SPF_ADDR_FLAG, 32'hD, 32'h0);
    $display("test backup done");
    bus(1'b1, `SPF_ADDR_CFGA, 32'h3);
    rstReq <= 1'b1;
    repeat (35) @(posedge clk);
    chk("cpu reset", 32'h1, 32'(cpuReset));
    rstReq <= 1'b0;
    wt();
    rdc("sense set", `SPF_ADDR_FLAG, 32'h1, 32'h1);
    rdc("cfgA cleared", `SPF_ADDR_CFGA, 32'hFFFF_FFFF, 32'h0);
    $display("test reset pin done");
    end_of_test();
  end
endmodule
